// *** hdl/quad_dac_params.svh ***
// constants for the quad converter serial link, both ends
// assumes a 100 MHz core clock on each end
`ifndef QUAD_DAC_PARAMS_SVH
`define QUAD_DAC_PARAMS_SVH
`define WORD_BITS 16
`define CODE_BITS 12
`define NUM_CHANNELS 4
`define SEL_HI_POS 15
`define SEL_LO_POS 14
`define SLEEP_POS 13
`define FAST_POS 12
`define CODE_HI_POS 11
`define BIT_CNT_W 5
`define CORE_PERIOD_NS 10
`define SCLK_MIN_PERIOD_NS 50
`define SCLK_HALF_CYCLES ((`SCLK_MIN_PERIOD_NS + 2 * `CORE_PERIOD_NS - 1) / (2 * `CORE_PERIOD_NS))
`define DIV_CNT_W 4
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define FAST_SETTLE_NS 3000
`define SLOW_SETTLE_NS 9000
`endif

// *** hdl/quad_dac_pkg.sv ***
// host state type for the quad converter link; both ends import the package, only the host uses it
// assumes the params header is included alongside
package quad_dac_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FRAME = 2'b01,
        ST_SHIFT = 2'b10,
        ST_DONE = 2'b11
    } host_state_t;
endpackage : quad_dac_pkg

// *** hdl/quad_dac_link_if.sv ***
// serial link wires between host and converter
// assumes both ends run their own core clock
`timescale 1ns/1ps
`default_nettype none
interface quad_dac_link_if;
    logic chip_sel_n;
    logic frame_sync;
    logic sclk;
    logic sdata;
    logic output_load_n;
    logic power_down_n;
    modport host (output chip_sel_n, output frame_sync, output sclk, output sdata,
                  output output_load_n, output power_down_n);
    modport device (input chip_sel_n, input frame_sync, input sclk, input sdata,
                    input output_load_n, input power_down_n);
endinterface : quad_dac_link_if
`default_nettype wire

// *** hdl/word_fifo.sv ***
// parameterised fifo with valid and ready on both sides
// assumes a single clock domain
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] next_wr_ptr;
    logic [AW:0] next_rd_ptr;
    logic push;
    logic pop;
    always_comb begin
        in_ready_o = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
        out_valid_o = wr_ptr != rd_ptr;
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        next_wr_ptr = wr_ptr + (AW+1)'(push);
        next_rd_ptr = rd_ptr + (AW+1)'(pop);
        out_data_o = mem[rd_ptr[AW-1:0]];
    end
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end
endmodule : word_fifo
`default_nettype wire

// *** hdl/quad_dac_host.sv ***
// host end: queues words, shifts them out as serial frames
// assumes the device samples data on serial clock falls
`timescale 1ns/1ps
`default_nettype none
`include "quad_dac_params.svh"
module quad_dac_host
    import quad_dac_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // word queue
    input wire logic word_valid_i,
    output logic word_ready_o,
    input wire logic [`WORD_BITS-1:0] word_i,
    // static controls and busy status
    input wire logic load_n_i,
    input wire logic power_down_n_i,
    output logic busy_o,
    // link
    quad_dac_link_if.host link
);
    logic q_valid;
    logic q_ready;
    logic [`WORD_BITS-1:0] q_data;
    host_state_t state, next_state;
    logic [`WORD_BITS-1:0] shreg, next_shreg;
    logic [`BIT_CNT_W-1:0] bits, next_bits;
    logic [`DIV_CNT_W-1:0] div, next_div;
    logic sclk, next_sclk;
    logic cs_n, next_cs_n;
    logic fs, next_fs;
    logic load_n, next_load_n;
    logic pd_n, next_pd_n;
    logic tick;
    word_fifo #(.WIDTH(`WORD_BITS), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .in_valid_i(word_valid_i),
        .in_ready_o(word_ready_o),
        .in_data_i(word_i),
        .out_valid_o(q_valid),
        .out_ready_i(q_ready),
        .out_data_o(q_data)
    );
    // ----------------------------------------
    // frame sequencer
    // ----------------------------------------
    always_comb begin
        tick = div == `DIV_CNT_W'(`SCLK_HALF_CYCLES - 1);
        next_div = tick ? '0 : div + `DIV_CNT_W'(1);
        next_state = state;
        next_shreg = shreg;
        next_bits = bits;
        next_sclk = sclk;
        next_cs_n = cs_n;
        next_fs = fs;
        next_load_n = load_n_i;
        next_pd_n = power_down_n_i;
        q_ready = 1'b0;
        case (state)
            ST_IDLE: begin
                next_sclk = 1'b1;
                next_fs = 1'b1;
                next_cs_n = 1'b1;
                if (q_valid && tick) begin
                    q_ready = 1'b1;
                    next_shreg = q_data;
                    next_cs_n = 1'b0;
                    next_state = ST_FRAME;
                end
            end
            ST_FRAME: begin
                if (tick) begin
                    next_fs = 1'b0;
                    next_bits = '0;
                    next_state = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (tick) begin
                    next_sclk = ~sclk;
                    if (!sclk) begin
                        next_shreg = {shreg[`WORD_BITS-2:0], 1'b0};
                        next_bits = bits + `BIT_CNT_W'(1);
                        if (bits == `BIT_CNT_W'(`WORD_BITS - 1)) begin
                            next_state = ST_DONE;
                        end
                    end
                end
            end
            ST_DONE: begin
                if (tick) begin
                    next_fs = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= ST_IDLE;
            shreg <= '0;
            bits <= '0;
            div <= '0;
            sclk <= 1'b1;
            cs_n <= 1'b1;
            fs <= 1'b1;
            load_n <= 1'b1;
            pd_n <= 1'b1;
        end else begin
            state <= next_state;
            shreg <= next_shreg;
            bits <= next_bits;
            div <= next_div;
            sclk <= next_sclk;
            cs_n <= next_cs_n;
            fs <= next_fs;
            load_n <= next_load_n;
            pd_n <= next_pd_n;
        end
    end
    assign busy_o = state != ST_IDLE;
    assign link.chip_sel_n = cs_n;
    assign link.frame_sync = fs;
    assign link.sclk = sclk;
    assign link.sdata = shreg[`WORD_BITS-1];
    assign link.output_load_n = load_n;
    assign link.power_down_n = pd_n;
endmodule : quad_dac_host
`default_nettype wire

// *** hdl/quad_dac_device.sv ***
// device end: captures serial words into four channel latches
// assumes link pins are asynchronous to core_clk_i
`timescale 1ns/1ps
`default_nettype none
`include "quad_dac_params.svh"
module quad_dac_device
    import quad_dac_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // link
    quad_dac_link_if.device link,
    // channel outputs
    output logic [`CODE_BITS-1:0] channel_out_first_o,
    output logic [`CODE_BITS-1:0] channel_out_second_o,
    output logic [`CODE_BITS-1:0] channel_out_third_o,
    output logic [`CODE_BITS-1:0] channel_out_fourth_o,
    output logic [`NUM_CHANNELS-1:0] channel_on_o,
    output logic [`NUM_CHANNELS-1:0] fast_settle_o
);
    localparam int NIN = 5;
    logic [NIN-1:0] sync1, sync2, prev;
    logic cs_n, fs, sck, sd, load_n, fs_prev, sck_prev;
    logic pd_s1;
    logic pd_n;
    logic [`NUM_CHANNELS-1:0] on_q;
    logic [`WORD_BITS-1:0] shreg, next_shreg;
    logic [`BIT_CNT_W-1:0] bits, next_bits;
    logic active, next_active;
    logic commit;
    logic [`WORD_BITS-1:0] cword;
    logic [1:0] csel;
    logic [`CODE_BITS-1:0] held [`NUM_CHANNELS];
    logic [`CODE_BITS-1:0] outv [`NUM_CHANNELS];
    logic [`NUM_CHANNELS-1:0] sleep, fastb;
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync1 <= 5'h1F;
            sync2 <= 5'h1F;
            prev <= 5'h1F;
            pd_s1 <= 1'b0;
            pd_n <= 1'b0;
        end else begin
            sync1 <= {link.chip_sel_n, link.frame_sync, link.sclk, link.sdata, link.output_load_n};
            sync2 <= sync1;
            prev <= sync2;
            pd_s1 <= link.power_down_n;
            pd_n <= pd_s1;
        end
    end
    assign {cs_n, fs, sck, sd, load_n} = sync2;
    assign fs_prev = prev[3];
    assign sck_prev = prev[2];
    // ----------------------------------------
    // serial capture
    // ----------------------------------------
    always_comb begin
        next_shreg = shreg;
        next_bits = bits;
        next_active = active;
        commit = 1'b0;
        cword = shreg;
        if (cs_n) begin
            next_active = 1'b0;
        end else if (fs_prev && !fs) begin
            next_active = 1'b1;
            next_bits = '0;
        end else if (active) begin
            if (fs && !fs_prev) begin
                next_active = 1'b0;
                commit = 1'b1;
            end else if (sck_prev && !sck) begin
                next_shreg = {shreg[`WORD_BITS-2:0], sd};
                next_bits = bits + `BIT_CNT_W'(1);
                if (bits == `BIT_CNT_W'(`WORD_BITS - 1)) begin
                    next_active = 1'b0;
                    commit = 1'b1;
                    cword = next_shreg;
                end
            end
        end
        csel = {cword[`SEL_HI_POS], cword[`SEL_LO_POS]};
    end
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shreg <= '0;
            bits <= '0;
            active <= 1'b0;
        end else begin
            shreg <= next_shreg;
            bits <= next_bits;
            active <= next_active;
        end
    end
    // ----------------------------------------
    // channel latches
    // ----------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < `NUM_CHANNELS; ch++) begin : g_ch
            logic [`CODE_BITS-1:0] next_held, next_out;
            logic next_sleep, next_fast, next_on;
            always_comb begin
                next_held = held[ch];
                next_sleep = sleep[ch];
                next_fast = fastb[ch];
                if (commit && csel == 2'(ch)) begin
                    next_held = cword[`CODE_HI_POS:0];
                    next_sleep = cword[`SLEEP_POS];
                    next_fast = cword[`FAST_POS];
                end
                next_out = load_n ? outv[ch] : next_held;
                next_on = pd_n && !next_sleep;
            end
            always_ff @(posedge core_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    held[ch] <= '0;
                    outv[ch] <= '0;
                    sleep[ch] <= 1'b0;
                    fastb[ch] <= 1'b0;
                    on_q[ch] <= 1'b0;
                end else begin
                    held[ch] <= next_held;
                    outv[ch] <= next_out;
                    sleep[ch] <= next_sleep;
                    fastb[ch] <= next_fast;
                    on_q[ch] <= next_on;
                end
            end
            assign channel_on_o[ch] = on_q[ch];
            assign fast_settle_o[ch] = fastb[ch];
        end
    endgenerate
    assign channel_out_first_o = outv[0];
    assign channel_out_second_o = outv[1];
    assign channel_out_third_o = outv[2];
    assign channel_out_fourth_o = outv[3];
endmodule : quad_dac_device
`default_nettype wire

// *** verification/quad_dac_link_sva.sv ***
// link wire checker for the quad converter serial link
// assumes both ends share core_clk_i and rstn_i
`timescale 1ns/1ps
`default_nettype none
module quad_dac_link_sva (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // link wires
    input wire logic chip_sel_n,
    input wire logic frame_sync,
    input wire logic sclk,
    input wire logic sdata
);
    // ----------------------------
    // serial clock falls per frame
    // ----------------------------
    logic [4:0] falls;
    logic [4:0] next_falls;
    logic sclk_d;
    logic fs_d;
    always_comb begin
        next_falls = falls;
        if (fs_d && !frame_sync) begin
            next_falls = 5'h00;
        end else if (sclk_d && !sclk && !frame_sync) begin
            next_falls = falls + 5'h01;
        end
    end
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            falls <= 5'h00;
            sclk_d <= 1'b1;
            fs_d <= 1'b1;
        end else begin
            falls <= next_falls;
            sclk_d <= sclk;
            fs_d <= frame_sync;
        end
    end
    // ----------------------------
    // assertions
    // ----------------------------
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);
    idle_frame_a: assert property (chip_sel_n |-> frame_sync)
        else $error("sync low without select");
    sel_setup_a: assert property ($fell(frame_sync) |-> !$past(chip_sel_n))
        else $error("frame started without select");
    first_fall_a: assert property ($fell(frame_sync) |-> ##[1:6] $fell(sclk))
        else $error("no clock fall after frame start");
    sclk_low_a: assert property ($fell(sclk) |-> !sclk [*3])
        else $error("serial clock low too short");
    sclk_high_a: assert property ($rose(sclk) |-> sclk [*3])
        else $error("serial clock high too short");
    fall_framed_a: assert property ($fell(sclk) |-> !frame_sync && !chip_sel_n)
        else $error("clock fall outside frame");
    data_setup_a: assert property ($fell(sclk) |-> $stable(sdata))
        else $error("data moved at sampling fall");
    word_len_a: assert property ($rose(frame_sync) |-> falls == 5'h10)
        else $error("frame not sixteen bits");
endmodule : quad_dac_link_sva
`default_nettype wire

// *** verification/testbench.sv ***
// self-checking bench: host and device joined over the link
// assumes design reset values and the host walk timing
`timescale 1ns/1ps
`default_nettype none
`include "quad_dac_params.svh"
module testbench;
    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic word_valid_i = 1'b0;
    logic [15:0] word_i = 16'h0000;
    logic load_n_i = 1'b0;
    logic power_down_n_i = 1'b1;
    logic word_ready_o;
    logic busy_o;
    logic [11:0] chan [4];
    logic [3:0] on_o;
    logic [3:0] fast_o;
    int failures = 0;
    int cmp_count = 0;
    logic [31:0] seed = 32'h9948;
    logic [11:0] held [4] = '{default: 12'h000};
    logic [11:0] applied [4] = '{default: 12'h000};
    logic [3:0] m_sleep = 4'h0;
    logic [3:0] m_fast = 4'h0;
    logic acc;
    logic [31:0] r;
    int n;
    always #5 core_clk_i = ~core_clk_i;
    // ----------------------------
    // design and checker
    // ----------------------------
    quad_dac_link_if link();
    quad_dac_host i_quad_dac_host (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .word_valid_i(word_valid_i),
        .word_ready_o(word_ready_o), .word_i(word_i), .load_n_i(load_n_i),
        .power_down_n_i(power_down_n_i), .busy_o(busy_o), .link(link));
    quad_dac_device i_quad_dac_device (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .link(link),
        .channel_out_first_o(chan[0]), .channel_out_second_o(chan[1]), .channel_out_third_o(chan[2]),
        .channel_out_fourth_o(chan[3]), .channel_on_o(on_o), .fast_settle_o(fast_o));
    quad_dac_link_sva i_quad_dac_link_sva (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .chip_sel_n(link.chip_sel_n), .frame_sync(link.frame_sync), .sclk(link.sclk), .sdata(link.sdata));
    // ----------------------------
    // tasks
    // ----------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic push(input logic [15:0] w);
        @(negedge core_clk_i);
        word_valid_i = 1'b1;
        word_i = w;
        acc = word_ready_o;
        if (acc) begin
            held[w[15:14]] = w[11:0];
            m_sleep[w[15:14]] = w[13];
            m_fast[w[15:14]] = w[12];
            if (!load_n_i) begin
                applied[w[15:14]] = w[11:0];
            end
        end
        @(posedge core_clk_i);
    endtask : push
    task automatic settle();
        int quiet;
        quiet = 0;
        @(negedge core_clk_i);
        word_valid_i = 1'b0;
        for (int k = 0; k < 4000 && quiet < 12; k++) begin
            @(negedge core_clk_i);
            quiet = (busy_o === 1'b0) ? quiet + 1 : 0;
        end
        check(quiet, 12);
    endtask : settle
    task automatic compare_all(input string name);
        for (int c = 0; c < 4; c++) begin
            check(chan[c], applied[c]);
        end
        check(on_o, {4{power_down_n_i}} & ~m_sleep);
        check(fast_o, m_fast);
        $display("test %s done", name);
    endtask : compare_all
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    // ----------------------------
    // tests
    // ----------------------------
    initial begin
        #400000;
        failures++;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge core_clk_i);
        @(negedge core_clk_i);
        rstn_i = 1'b1;
        repeat (5) @(negedge core_clk_i);
        compare_all("reset");
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            push({i[1:0], i[3:2], r[11:0]});
            settle();
            compare_all("word");
        end
        load_n_i = 1'b1;
        repeat (8) @(negedge core_clk_i);
        for (int c = 0; c < 4; c++) begin
            r = rnd();
            push({c[1:0], r[13:0]});
        end
        settle();
        compare_all("load held");
        load_n_i = 1'b0;
        applied = held;
        repeat (10) @(negedge core_clk_i);
        compare_all("load release");
        power_down_n_i = 1'b0;
        repeat (8) @(negedge core_clk_i);
        compare_all("power down");
        power_down_n_i = 1'b1;
        repeat (8) @(negedge core_clk_i);
        n = 0;
        acc = 1'b1;
        for (int k = 0; k < 40 && acc; k++) begin
            r = rnd();
            push(r[15:0]);
            n += int'(acc);
        end
        check(n >= 16 && n <= 17, 1);
        settle();
        compare_all("fill");
        finish_test();
    end
endmodule : testbench
`default_nettype wire
